// ===== monitor_params.svh
// Constants: offsets, fields, reset values and timing of the monitor block
`ifndef MONITOR_PARAMS_SVH
`define MONITOR_PARAMS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS      25
`define FRAME_TIME_US      30000
`define CHANNEL_COUNT      5
`define SLOT_CYCLES_DEF    ((`FRAME_TIME_US * 1000) / `CLK_PERIOD_NS / `CHANNEL_COUNT)

// ****************************************************************
// Register offsets (word index)
// ****************************************************************
`define OFS_RESULT         9'h000
`define OFS_ALARM_FLAGS    9'h028
`define OFS_WARN_FLAGS     9'h029
`define OFS_DONE           9'h02A
`define OFS_INT_EN         9'h02B
`define OFS_CTRL           9'h02C
`define OFS_PIN_STATUS     9'h02D
`define OFS_WIPER          9'h02E
`define OFS_MANUAL_A       9'h082
`define OFS_MANUAL_B       9'h083
`define OFS_LUT_FIRST      9'h180
`define OFS_LUT_LAST       9'h1C7

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define CTRL_INDEX_BIT     0
`define CTRL_FAULT_BIT     1
`define CTRL_RESET         2'h0
`define INT_EN_RESET       5'h00
`define MANUAL_RESET       8'h00
`define LIMIT_RESET        16'h0000
`define LUT_RESET          16'h0000
`define LUT_DEPTH          72

// ****************************************************************
// Scaling masks and temperature indexing
// ****************************************************************
`define TEMP_SCALE_MASK    16'hFFFC
`define VOLT_SCALE_MASK    16'hFFF8
`define LOW_RES_MASK       16'hFFF8
`define INDEX_OFFSET_DEG   9'h028
`define INDEX_SPAN_DEG     9'h08E
`define INDEX_FIRST        8'h80
`define INDEX_LAST         8'hC7

`endif

// ===== monitor_pkg.sv
// Types shared by the monitor block
package monitor_pkg;

    typedef enum logic [2:0] {
        CH_TEMP    = 3'h0,
        CH_SUPPLY  = 3'h1,
        CH_INPUT_A = 3'h2,
        CH_INPUT_B = 3'h3,
        CH_INPUT_C = 3'h4
    } channel_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_START = 2'h1,
        ST_WAIT  = 2'h3,
        ST_STORE = 2'h2
    } seq_state_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [8:0]  addr;
        logic [15:0] wdata;
    } bus_req_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } conv_result_type;

endpackage : monitor_pkg

// ===== temp_index_map.sv
// Maps a temperature word to its trim table address
`timescale 1ns/1ps
`default_nettype none
`include "monitor_params.svh"

module temp_index_map (
    // Temperature in, table address out
    input  wire logic [15:0] temp_word,
    output logic      [7:0]  table_addr
);

    wire logic signed [8:0] ofs_w;
    wire logic              below_w;
    wire logic              above_w;
    wire logic        [7:0] step_w;

    // Whole degrees plus forty; each two degrees is one table step
    assign ofs_w   = $signed({temp_word[15], temp_word[15:8]})
                   + $signed(`INDEX_OFFSET_DEG);
    assign below_w = ofs_w <= $signed(9'h000);
    assign above_w = ofs_w >= $signed(`INDEX_SPAN_DEG);
    assign step_w  = {1'b0, ofs_w[7:1]};
    assign table_addr = below_w ? `INDEX_FIRST :
                        above_w ? `INDEX_LAST  :
                        8'(`INDEX_FIRST + step_w);

endmodule : temp_index_map

`default_nettype wire

// ===== monitor_alarm_and_trim_control.sv
// Monitor sequencer, limit flags, pin buffers and trim resistor control
//
// How it works
// - conversion done sets per-channel pollable bit
// - alarm and warning flags, high and low
// - per-channel enable for limit events
// - result is left-justified sixteen-bit word
// - low-resistance variant zeroes three lowest bits
// - five channels refreshed round-robin per frame
// - limit comparison runs without host command
// - flag set within fixed latency
// - factory spans clamp result low bits
// - supply/inputs unsigned, temperature two's complement
// - results passed unscaled at factory weights
// - no protection while protect pin low
// - protect pin pulled up, open means protect
// - two buffers drive open-drain outputs
// - first drain output also signals limit faults
// - two wiper positions set independently
// - table entry per two degrees, both resistors
// - temperature maps to table address 80h..C7h
// - temperature upper byte signed degrees
// - index disabled means manual wiper bytes
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "monitor_params.svh"

module monitor_alarm_and_trim_control
    import monitor_pkg::*;
#(
    parameter int SLOT_CYCLES = `SLOT_CYCLES_DEF,
    parameter bit LOW_RES     = 1'b0
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            sys_rst,
    // Register port
    input  wire bus_req_type     bus_req,
    output logic [15:0]          rd_data,
    // Converter
    output logic                 conv_start,
    output channel_type          conv_channel,
    input  wire conv_result_type conv_res,
    // Pins
    input  wire logic            write_protect_pin,
    input  wire logic            buffer_input_a,
    input  wire logic            buffer_input_b,
    input  wire logic            drain_output_a_i,
    output logic                 drain_output_a_o,
    output logic                 drain_output_a_oe,
    input  wire logic            drain_output_b_i,
    output logic                 drain_output_b_o,
    output logic                 drain_output_b_oe,
    // Resistor wipers
    output logic [7:0]           wiper_a_pos,
    output logic [7:0]           wiper_b_pos
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    wire  logic wp_s;
    wire  logic in_a_s;
    wire  logic in_b_s;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_q <= 5'h1F;
            sync2_q <= 5'h1F;
        end else begin
            sync1_q <= {drain_output_b_i, drain_output_a_i,
                        buffer_input_b, buffer_input_a, write_protect_pin};
            sync2_q <= sync1_q;
        end
    end

    // Reset to the pulled-up idle level: protected, outputs released
    assign wp_s   = sync2_q[0];
    assign in_a_s = sync2_q[1];
    assign in_b_s = sync2_q[2];

    // ****************************************************************
    // Round-robin sequencer
    // ****************************************************************
    seq_state_type state_q;
    channel_type   ch_q;
    logic [23:0]   slot_cnt_q;
    logic          kick_q;
    wire  logic    slot_done_w;
    wire  logic    store_w;
    wire  channel_type ch_next_w;
    wire  logic [15:0] scale_w;
    wire  logic [15:0] masked_w;

    assign slot_done_w = slot_cnt_q >= 24'(SLOT_CYCLES - 1);
    assign store_w     = state_q == ST_STORE;
    assign ch_next_w   = (ch_q == CH_INPUT_C) ? CH_TEMP
                       : channel_type'(ch_q + 3'h1);
    assign conv_start   = state_q == ST_START;
    assign conv_channel = ch_q;

    // Temperature keeps one more bit than the voltages unless LOW_RES is set
    assign scale_w  = ((ch_q == CH_TEMP) ? `TEMP_SCALE_MASK
                                         : `VOLT_SCALE_MASK)
                    & (LOW_RES ? `LOW_RES_MASK : 16'hFFFF);
    assign masked_w = conv_res.data & scale_w;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            ch_q    <= CH_TEMP;
            kick_q  <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (slot_done_w || kick_q) begin
                        state_q <= ST_START;
                        kick_q  <= 1'b0;
                    end
                end
                ST_START: state_q <= ST_WAIT;
                ST_WAIT: begin
                    if (conv_res.valid) begin
                        state_q <= ST_STORE;
                    end
                end
                ST_STORE: begin
                    state_q <= ST_IDLE;
                    ch_q    <= ch_next_w;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Slot timer restarts with each conversion so a slow converter
    // stretches the frame rather than skipping a channel
    always_ff @(posedge clk) begin
        if (sys_rst || (state_q == ST_IDLE && (slot_done_w || kick_q))) begin
            slot_cnt_q <= 24'h00_0000;
        end else if (!slot_done_w) begin
            slot_cnt_q <= slot_cnt_q + 24'h00_0001;
        end
    end

    // ****************************************************************
    // Register decode
    // ****************************************************************
    logic [15:0] result_q [`CHANNEL_COUNT];
    logic [15:0] limit_q  [4][`CHANNEL_COUNT];
    logic [15:0] lut_q    [`LUT_DEPTH];
    logic [4:0]  seen_q;
    logic [4:0]  done_q;
    logic [4:0]  int_en_q;
    logic [1:0]  ctrl_q;
    logic [7:0]  manual_a_q;
    logic [7:0]  manual_b_q;
    logic [4:0]  ah_q;
    logic [4:0]  al_q;
    logic [4:0]  wh_q;
    logic [4:0]  wl_q;
    logic [15:0] rd_data_q;

    wire logic [8:0]  addr_w;
    wire logic [2:0]  sel_ch_w;
    wire logic [2:0]  kind_full_w;
    wire logic [1:0]  kind_w;
    wire logic [6:0]  lut_sel_w;
    wire logic        ch_ok_w;
    wire logic        hit_result_w;
    wire logic        hit_limit_w;
    wire logic        hit_lut_w;
    wire logic        wr_ok_w;
    wire logic        done_clr_w;
    wire logic [15:0] rd_mux_w;

    assign addr_w       = bus_req.addr;
    assign sel_ch_w     = addr_w[2:0];
    assign kind_full_w  = addr_w[5:3] - 3'h1;
    assign kind_w       = kind_full_w[1:0];
    assign lut_sel_w    = addr_w[6:0];
    assign ch_ok_w      = sel_ch_w < 3'h5;
    assign hit_result_w = addr_w[8:3] == 6'h00 && ch_ok_w;
    assign hit_limit_w  = addr_w[8:6] == 3'h0 && addr_w[5:3] != 3'h0
                       && addr_w[5:3] <= 3'h4 && ch_ok_w;
    assign hit_lut_w    = addr_w >= `OFS_LUT_FIRST
                       && addr_w <= `OFS_LUT_LAST;
    // Protect pin high blocks every write
    assign wr_ok_w      = bus_req.wr && !wp_s;
    assign done_clr_w   = bus_req.rd && addr_w == `OFS_DONE;

    assign rd_mux_w =
        hit_result_w ? result_q[sel_ch_w] :
        hit_limit_w  ? limit_q[kind_w][sel_ch_w] :
        hit_lut_w    ? lut_q[lut_sel_w] :
        addr_w == `OFS_ALARM_FLAGS ? {3'h0, al_q, 3'h0, ah_q} :
        addr_w == `OFS_WARN_FLAGS  ? {3'h0, wl_q, 3'h0, wh_q} :
        addr_w == `OFS_DONE        ? {11'h000, done_q} :
        addr_w == `OFS_INT_EN      ? {11'h000, int_en_q} :
        addr_w == `OFS_CTRL        ? {14'h0000, ctrl_q} :
        addr_w == `OFS_PIN_STATUS  ? {11'h000, sync2_q} :
        addr_w == `OFS_WIPER       ? {wiper_b_pos, wiper_a_pos} :
        addr_w == `OFS_MANUAL_A    ? {8'h00, manual_a_q} :
        addr_w == `OFS_MANUAL_B    ? {8'h00, manual_b_q} :
        16'h0000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_q <= 16'h0000;
        end else begin
            rd_data_q <= bus_req.rd ? rd_mux_w : 16'h0000;
        end
    end
    assign rd_data = rd_data_q;

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_en_q   <= `INT_EN_RESET;
            ctrl_q     <= `CTRL_RESET;
            manual_a_q <= `MANUAL_RESET;
            manual_b_q <= `MANUAL_RESET;
        end else if (wr_ok_w) begin
            if (addr_w == `OFS_INT_EN) begin
                int_en_q <= bus_req.wdata[4:0];
            end
            if (addr_w == `OFS_CTRL) begin
                ctrl_q <= bus_req.wdata[1:0];
            end
            if (addr_w == `OFS_MANUAL_A) begin
                manual_a_q <= bus_req.wdata[7:0];
            end
            if (addr_w == `OFS_MANUAL_B) begin
                manual_b_q <= bus_req.wdata[7:0];
            end
        end
    end

    // ****************************************************************
    // Per-channel results, limits and flags
    // ****************************************************************
    logic [4:0] ah_d;
    logic [4:0] al_d;
    logic [4:0] wh_d;
    logic [4:0] wl_d;

    for (genvar c = 0; c < `CHANNEL_COUNT; c++) begin : g_chan
        wire logic        sgn_w;
        wire logic [16:0] res_x;
        wire logic [16:0] lim_x [4];

        // Only the temperature channel compares as signed
        assign sgn_w = c == 0;
        assign res_x = {sgn_w & result_q[c][15], result_q[c]};
        for (genvar k = 0; k < 4; k++) begin : g_kind
            assign lim_x[k] = {sgn_w & limit_q[k][c][15], limit_q[k][c]};
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    limit_q[k][c] <= `LIMIT_RESET;
                end else if (wr_ok_w && hit_limit_w && kind_w == 2'(k)
                             && sel_ch_w == 3'(c)) begin
                    limit_q[k][c] <= bus_req.wdata;
                end
            end
        end
        // Limits 0/1 are alarm high/low, 2/3 are warning high/low
        assign ah_d[c] = seen_q[c] & ($signed(res_x) > $signed(lim_x[0]));
        assign al_d[c] = seen_q[c] & ($signed(res_x) < $signed(lim_x[1]));
        assign wh_d[c] = seen_q[c] & ($signed(res_x) > $signed(lim_x[2]));
        assign wl_d[c] = seen_q[c] & ($signed(res_x) < $signed(lim_x[3]));

        always_ff @(posedge clk) begin
            if (sys_rst) begin
                result_q[c] <= 16'h0000;
                seen_q[c]   <= 1'b0;
                done_q[c]   <= 1'b0;
            end else begin
                if (state_q == ST_WAIT && conv_res.valid
                    && ch_q == channel_type'(c)) begin
                    result_q[c] <= masked_w;
                    seen_q[c]   <= 1'b1;
                end
                // A new conversion wins over a clearing read
                done_q[c] <= (done_q[c] & ~done_clr_w)
                           | (store_w && ch_q == channel_type'(c));
            end
        end
    end

    // Flags follow the results every cycle, no host trigger needed
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ah_q <= 5'h00;
            al_q <= 5'h00;
            wh_q <= 5'h00;
            wl_q <= 5'h00;
        end else begin
            ah_q <= ah_d;
            al_q <= al_d;
            wh_q <= wh_d;
            wl_q <= wl_d;
        end
    end

    // ****************************************************************
    // Trim table and wipers
    // ****************************************************************
    wire logic [7:0]  table_addr_w;
    wire logic [15:0] lut_entry_w;

    temp_index_map u_index (
        .temp_word  (result_q[0]),
        .table_addr (table_addr_w)
    );

    for (genvar e = 0; e < `LUT_DEPTH; e++) begin : g_lut
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                lut_q[e] <= `LUT_RESET;
            end else if (wr_ok_w && hit_lut_w && lut_sel_w == 7'(e)) begin
                lut_q[e] <= bus_req.wdata;
            end
        end
    end

    assign lut_entry_w = lut_q[table_addr_w[6:0]];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wiper_a_pos <= 8'h00;
            wiper_b_pos <= 8'h00;
        end else if (ctrl_q[`CTRL_INDEX_BIT]) begin
            wiper_a_pos <= lut_entry_w[7:0];
            wiper_b_pos <= lut_entry_w[15:8];
        end else begin
            wiper_a_pos <= manual_a_q;
            wiper_b_pos <= manual_b_q;
        end
    end

    // ****************************************************************
    // Open-drain buffers
    // ****************************************************************
    wire  logic fault_w;
    logic       oe_a_q;
    logic       oe_b_q;

    assign fault_w = ctrl_q[`CTRL_FAULT_BIT]
                   & |((ah_q | al_q) & int_en_q);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oe_a_q <= 1'b0;
            oe_b_q <= 1'b0;
        end else begin
            oe_a_q <= !in_a_s || fault_w;
            oe_b_q <= !in_b_s;
        end
    end

    assign drain_output_a_o  = 1'b0;
    assign drain_output_b_o  = 1'b0;
    assign drain_output_a_oe = oe_a_q;
    assign drain_output_b_oe = oe_b_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence start_then_wait;
        conv_start ##1 (state_q == ST_WAIT);
    endsequence

    done_bit_set_a: assert property (store_w |=> done_q[$past(ch_q)])
        else $error("done bit not set after store");
    alarm_low_flag_a: assert property (
        al_q[1] == $past(seen_q[1] && result_q[1] < limit_q[1][1]))
        else $error("supply low alarm wrong");
    flag_latency_a: assert property (
        (state_q == ST_WAIT && conv_res.valid && ch_q == CH_SUPPLY
         && masked_w > limit_q[0][1]) |-> ##2 ah_q[1])
        else $error("alarm not raised in two cycles");
    result_mask_a: assert property (store_w |->
        result_q[ch_q][1:0] == 2'h0 && (ch_q == CH_TEMP
        || result_q[ch_q][2:0] == 3'h0))
        else $error("result low bits not masked");
    chan_order_a: assert property (store_w |=> ch_q == $past(ch_next_w))
        else $error("channel order broken");
    conv_handshake_a: assert property (conv_start |-> start_then_wait)
        else $error("start not followed by wait");
    protect_block_a: assert property (
        (bus_req.wr && addr_w == `OFS_CTRL) |=>
        (ctrl_q == ($past(wp_s) ? $past(ctrl_q) : $past(bus_req.wdata[1:0]))))
        else $error("write protect misapplied");
    buffer_b_a: assert property (##1 drain_output_b_oe == !$past(in_b_s))
        else $error("buffer b mismatch");
    fault_out_a: assert property (fault_w |=> drain_output_a_oe)
        else $error("fault did not pull output a");
    manual_wiper_a: assert property (
        !ctrl_q[`CTRL_INDEX_BIT] |=> wiper_a_pos == $past(manual_a_q))
        else $error("manual wiper not applied");
    table_range_a: assert property (
        table_addr_w >= `INDEX_FIRST && table_addr_w <= `INDEX_LAST)
        else $error("table address out of range");

endmodule : monitor_alarm_and_trim_control

`default_nettype wire

// ===== conv_model.sv
// Converter stand-in that answers each start after a fixed delay
`timescale 1ns/1ps
`default_nettype none

module conv_model
    import monitor_pkg::*;
#(
    parameter int DELAY = 3
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Request and sample values
    input  wire logic        conv_start,
    input  wire channel_type conv_channel,
    input  wire logic [79:0] samples,
    // Answer
    output var conv_result_type conv_res
);
    int          wait_q;
    channel_type chan_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wait_q   <= 0;
            chan_q   <= CH_TEMP;
            conv_res <= '0;
        end else begin
            conv_res.valid <= 1'b0;
            // Data outside an answer is junk, inverted every cycle so it never holds
            conv_res.data  <= ~conv_res.data;
            if (conv_start) begin
                wait_q <= DELAY;
                chan_q <= conv_channel;
            end else if (wait_q == 1) begin
                wait_q   <= 0;
                conv_res <= '{1'b1, samples[16*int'(chan_q) +: 16]};
            end else if (wait_q > 1) begin
                wait_q <= wait_q - 1;
            end
        end
    end
endmodule : conv_model

`default_nettype wire

// ===== tb_monitor_alarm_and_trim_control.sv
// Self-checking bench for the monitor, flags, pins and trim wipers
`timescale 1ns/1ps
`default_nettype none
`include "monitor_params.svh"

module tb_monitor_alarm_and_trim_control
    import monitor_pkg::*;
    ;
    localparam int SLOT = 20;
    logic            clk, sys_rst, protect, in_a, in_b;
    bus_req_type     req;
    logic [15:0]     rd_data;
    logic            conv_start, a_o, a_oe, b_o, b_oe;
    channel_type     conv_channel;
    conv_result_type conv_res;
    logic [7:0]      wip_a, wip_b;
    logic [79:0]     samples;
    int              num_errors, cmp_count;

    monitor_alarm_and_trim_control #(.SLOT_CYCLES(SLOT)) dut (
        .clk(clk), .sys_rst(sys_rst), .bus_req(req), .rd_data(rd_data),
        .conv_start(conv_start), .conv_channel(conv_channel),
        .conv_res(conv_res), .write_protect_pin(protect),
        .buffer_input_a(in_a), .buffer_input_b(in_b),
        .drain_output_a_i(~a_oe), .drain_output_a_o(a_o),
        .drain_output_a_oe(a_oe), .drain_output_b_i(~b_oe),
        .drain_output_b_o(b_o), .drain_output_b_oe(b_oe),
        .wiper_a_pos(wip_a), .wiper_b_pos(wip_b));

    conv_model #(.DELAY(3)) conv_u (
        .clk(clk), .sys_rst(sys_rst), .conv_start(conv_start),
        .conv_channel(conv_channel), .samples(samples),
        .conv_res(conv_res));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ********
    // Shared tasks
    // ********
    task automatic check_word(input logic [15:0] got, exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t: %s got %h", $time, m, got);
        end
    endtask : check_word

    task automatic check_bit(input logic got, exp, input string m);
        check_word({15'h0000, got}, {15'h0000, exp}, m);
    endtask : check_bit

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask : cycles

    task automatic bus_write(input logic [8:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
    endtask : bus_write

    task automatic bus_read(input logic [8:0] a, output logic [15:0] d);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        d = rd_data;
    endtask : bus_read

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    // ********
    // Scenarios
    // ********
    task automatic test_order();
        int n;
        for (int k = 0; k < 6; k++) begin
            n = 0;
            @(negedge clk);
            while (conv_start !== 1'b1 && n < 200) begin
                @(negedge clk);
                n++;
            end
            if (n == 200) begin
                num_errors++;
                print_verdict();
            end
            check_word(16'(conv_channel), 16'(k % 5), "order");
            if (k > 0) check_word(16'(n + 1), 16'(SLOT), "slot");
        end
        $display("test finished: order");
    endtask : test_order

    task automatic test_results();
        logic [15:0] exp [5] = '{16'h1904, 16'hABC8, 16'h1230,
                                 16'hFFF8, 16'h0000};
        logic [15:0] d;
        cycles(10);
        bus_read(`OFS_DONE, d);
        check_word(d, 16'h001F, "done bits");
        for (int c = 0; c < 5; c++) begin
            bus_read(9'(c), d);
            check_word(d, exp[c], "result");
        end
        bus_read(`OFS_RESULT, d);
        check_word({4'h0, d[15:4]}, 16'h0190, "whole");
        $display("test finished: results");
    endtask : test_results

    task automatic test_protect();
        logic [15:0] d;
        bus_write(`OFS_MANUAL_A, 16'h0077);
        bus_write(`OFS_CTRL, 16'h0003);
        bus_read(`OFS_MANUAL_A, d);
        check_word(d, 16'h0000, "protected");
        bus_read(`OFS_CTRL, d);
        check_word(d, 16'h0000, "ctrl locked");
        @(posedge clk);
        protect <= 1'b0;
        cycles(4);
        bus_write(`OFS_MANUAL_A, 16'h0011);
        bus_write(`OFS_MANUAL_B, 16'h0022);
        bus_read(`OFS_MANUAL_A, d);
        check_word(d, 16'h0011, "unprotected");
        cycles(2);
        @(negedge clk);
        check_word({wip_b, wip_a}, 16'h2211, "manual");
        $display("test finished: protect");
    endtask : test_protect

    task automatic test_flags();
        logic [15:0] d;
        // Temperature low alarm limit above the 25 degC reading
        bus_write(9'h010, 16'h2000);
        cycles(3);
        bus_read(`OFS_ALARM_FLAGS, d);
        check_word(d, 16'h010F, "alarms");
        bus_read(`OFS_WARN_FLAGS, d);
        check_word(d, 16'h000F, "warnings");
        bus_write(`OFS_INT_EN, 16'h0010);
        bus_write(`OFS_CTRL, 16'h0002);
        cycles(2);
        @(negedge clk);
        check_bit(a_oe, 1'b0, "fault masked");
        bus_write(`OFS_INT_EN, 16'h0001);
        cycles(2);
        @(negedge clk);
        check_bit(a_oe, 1'b1, "fault");
        bus_write(`OFS_CTRL, 16'h0000);
        $display("test finished: flags");
    endtask : test_flags

    task automatic test_index();
        // 25 degC is 65 degrees above the bottom, entry 32
        bus_write(9'h1A0, 16'h5A3C);
        bus_write(`OFS_LUT_LAST, 16'hC3A5);
        bus_write(`OFS_CTRL, 16'h0001);
        cycles(3);
        @(negedge clk);
        check_word({wip_b, wip_a}, 16'h5A3C, "indexed");
        @(posedge clk);
        samples[15:0] <= 16'h7FFC;
        cycles(120);
        @(negedge clk);
        check_word({wip_b, wip_a}, 16'hC3A5, "top entry");
        $display("test finished: index");
    endtask : test_index

    task automatic test_buffers();
        logic [15:0] d;
        @(posedge clk);
        in_a <= 1'b0;
        in_b <= 1'b0;
        cycles(4);
        @(negedge clk);
        check_bit(a_oe & b_oe, 1'b1, "pull low");
        @(posedge clk);
        in_a <= 1'b1;
        in_b <= 1'b1;
        cycles(4);
        @(negedge clk);
        check_bit(a_oe | b_oe | a_o | b_o, 1'b0, "release");
        bus_read(`OFS_PIN_STATUS, d);
        check_word(d, 16'h001E, "pins");
        $display("test finished: buffers");
    endtask : test_buffers

    initial begin
        sys_rst    = 1'b1;
        protect    = 1'b1;
        in_a       = 1'b1;
        in_b       = 1'b1;
        req        = '0;
        samples    = 80'h0007_FFFF_1234_ABCF_1907;
        num_errors = 0;
        cmp_count  = 0;
        cycles(16);
        sys_rst <= 1'b0;
        @(negedge clk);
        check_word({wip_b, wip_a} | rd_data | {14'h0000, a_oe, b_oe},
                   16'h0000, "reset");
        test_order();
        test_results();
        test_protect();
        test_flags();
        test_index();
        test_buffers();
        print_verdict();
    end
endmodule : tb_monitor_alarm_and_trim_control

`default_nettype wire
